// file: core/pcgc_pkg.sv
// Constants for the clock group control block: map, fields, resets, counts
package pcgc_pkg;

    // ****************************************************************
    // Register addresses in the I/O space
    // ****************************************************************
    localparam logic [15:0] PCGC_CSR_ADDR = 16'h1c80;
    localparam logic [15:0] PCGC_CORESEL_ADDR = 16'h1c82;
    localparam logic [15:0] PCGC_MULT_ADDR = 16'h1c88;
    localparam logic [15:0] PCGC_PRESCALE_ADDR = 16'h1c8a;
    localparam logic [15:0] PCGC_FASTDIV_ADDR = 16'h1c8c;
    localparam logic [15:0] PCGC_SLOWDIV_ADDR = 16'h1c8e;
    localparam logic [15:0] PCGC_MEMDIV_ADDR = 16'h1c90;
    localparam logic [15:0] PCGC_OSCDIV_ADDR = 16'h1c92;
    localparam logic [15:0] PCGC_WAKEUP_ADDR = 16'h1c98;
    localparam logic [15:0] PCGC_CLKOUT_ADDR = 16'h8400;
    localparam logic [15:0] PCGC_CLKMODE_ADDR = 16'h8c00;

    // ****************************************************************
    // Plain stored words: index, address and reset value
    // ****************************************************************
    localparam int PCGC_PLAIN_NUM = 8;
    localparam int PCGC_IDX_CORESEL = 0;
    localparam int PCGC_IDX_FASTDIV = 1;
    localparam int PCGC_IDX_SLOWDIV = 2;
    localparam int PCGC_IDX_MEMDIV = 3;
    localparam int PCGC_IDX_OSCDIV = 4;
    localparam int PCGC_IDX_WAKEUP = 5;
    localparam int PCGC_IDX_CLKOUT = 6;
    localparam int PCGC_IDX_CLKMODE = 7;
    localparam logic [15:0] PCGC_PLAIN_ADDR [PCGC_PLAIN_NUM] = '{
        PCGC_CORESEL_ADDR, PCGC_FASTDIV_ADDR, PCGC_SLOWDIV_ADDR,
        PCGC_MEMDIV_ADDR, PCGC_OSCDIV_ADDR, PCGC_WAKEUP_ADDR,
        PCGC_CLKOUT_ADDR, PCGC_CLKMODE_ADDR};
    localparam logic [15:0] PCGC_PLAIN_RST [PCGC_PLAIN_NUM] = '{
        16'h000b, 16'h0003, 16'h0003, 16'h0003,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // ****************************************************************
    // Control/status fields
    // ****************************************************************
    localparam int PCGC_CSR_STABLE_BIT = 6;
    localparam int PCGC_CSR_LOCK_BIT = 5;
    localparam int PCGC_CSR_PLLRESET_BIT = 3;
    localparam int PCGC_CSR_OSCPD_BIT = 2;
    localparam int PCGC_CSR_PLLPD_BIT = 1;
    localparam int PCGC_CSR_MODE_BIT = 0;
    localparam logic PCGC_PLLRESET_RST = 1'b1;
    localparam logic PCGC_OSCPD_RST = 1'b0;
    localparam logic PCGC_PLLPD_RST = 1'b0;
    localparam logic PCGC_MODE_RST = 1'b0;

    // ****************************************************************
    // Multiplier and prescaler fields
    // ****************************************************************
    localparam int PCGC_FIELD_W = 5;
    localparam logic [4:0] PCGC_MULT_RST = 5'h00;
    localparam logic [4:0] PCGC_MULT_MIN = 5'h02;
    localparam logic [4:0] PCGC_MULT_MAX = 5'h0f;
    localparam logic [4:0] PCGC_PRESCALE_RST = 5'h00;
    localparam int PCGC_PRESCALE_EN_BIT = 15;
    localparam logic PCGC_PRESCALE_EN_RST = 1'b1;
    localparam int PCGC_CLKMODE_SRC_BIT = 0;

    // ****************************************************************
    // Oscillator stabilisation, counted in reference clock cycles
    // ****************************************************************
    localparam int PCGC_OSC_STABLE_REF_CYCLES = 41032;
    localparam int PCGC_OSC_CNT_W = 16;

endpackage

// file: core/pcgc_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module pcgc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule

// file: core/pcgc_clock_control.sv
// Clock generator control: register map, PLL control, memory clock select
//
// Behaviour
// - Select pin low: memory clock from bridge clock; high: external pin.
// - External memory clock source may cost throughput; design tolerates it.
// - Core group changes propagate into fast, slow and memory groups.
// - Clock registers reachable in I/O space at their printed addresses.
// - Stable bit 6 reads 0 while counting, 1 when done, disabled or test.
// - Lock bit 5 reads 0 while acquiring, 1 once PLL is locked.
// - PLL reset bit 3 resets to 1 and holds the PLL in reset.
// - Oscillator power-down bit 2 waits for idle with crystal, else at once.
// - PLL power-down bit 1 resets to 0; writing 1 powers PLL down.
// - Control/status bits 15:7 and 4 read zero and ignore writes.
// - Mode bit 0 resets to bypass; 1 feeds group dividers from PLL.
// - Multiplier codes 2 to 15 valid; all other codes reserved.
// - Prescaler divides by its code plus one, 1 to 32.
`timescale 1ns/1ps
module pcgc_clock_control
    import pcgc_pkg::*;
#(
    parameter int OSC_STABLE_CYCLES = PCGC_OSC_STABLE_REF_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [15:0] io_wdata_i,
    output logic [15:0] io_rdata_o,
    input wire logic memif_clock_source_pin_i,
    input wire logic memif_external_clock_pin_i,
    input wire logic bridge_clk_i,
    output logic memif_clk_o,
    output logic memif_ext_src_o,
    input wire logic pll_lock_raw_i,
    input wire logic osc_count_disable_i,
    input wire logic test_mode_i,
    input wire logic clockgen_idle_i,
    output logic pll_reset_o,
    output logic pll_powerdown_o,
    output logic osc_powerdown_o,
    output logic group_src_pll_o,
    output logic [4:0] multiplier_field_o,
    output logic multiplier_valid_o,
    output logic [3:0] multiplier_factor_o,
    output logic [4:0] prescaler_field_o,
    output logic [5:0] prescaler_divisor_o,
    output logic prescaler_enable_o,
    output logic [15:0] fast_divider_field_o,
    output logic [15:0] slow_divider_field_o,
    output logic [15:0] memif_divider_field_o,
    output logic [15:0] core_clock_source_select_o,
    output logic lock_status_o,
    output logic osc_stable_o,
    output logic lock_event_o
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [3:0] pins_sync;

    // Select pin, lock, counter disable strap and test mode
    pcgc_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .async_i({test_mode_i, osc_count_disable_i, pll_lock_raw_i,
            memif_clock_source_pin_i}),
        .sync_o(pins_sync)
    );

    wire memif_sel_sync = pins_sync[0];
    wire lock_sync = pins_sync[1];
    wire cnt_disable_sync = pins_sync[2];
    wire test_sync = pins_sync[3];

    // ****************************************************************
    // Memory interface clock source
    // ****************************************************************
    // Glitch-free switching is left to the clock tree; external source
    // is asynchronous to the bridge, so the interface resynchronises
    assign memif_ext_src_o = memif_sel_sync;
    assign memif_clk_o = memif_sel_sync ? memif_external_clock_pin_i
                                        : bridge_clk_i;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire hit_csr = (io_addr_i == PCGC_CSR_ADDR);
    wire hit_mult = (io_addr_i == PCGC_MULT_ADDR);
    wire hit_pre = (io_addr_i == PCGC_PRESCALE_ADDR);
    wire wr_csr = io_wr_i & hit_csr;
    wire wr_mult = io_wr_i & hit_mult;
    wire wr_pre = io_wr_i & hit_pre;

    // ****************************************************************
    // Control/status register
    // ****************************************************************
    logic pll_rst_ff;
    logic osc_pd_ff;
    logic pll_pd_ff;
    logic pll_mode_ff;

    // Only the four writable bits are stored
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            pll_rst_ff <= PCGC_PLLRESET_RST;
            osc_pd_ff <= PCGC_OSCPD_RST;
            pll_pd_ff <= PCGC_PLLPD_RST;
            pll_mode_ff <= PCGC_MODE_RST;
        end
        else if (wr_csr)
        begin
            pll_rst_ff <= io_wdata_i[PCGC_CSR_PLLRESET_BIT];
            osc_pd_ff <= io_wdata_i[PCGC_CSR_OSCPD_BIT];
            pll_pd_ff <= io_wdata_i[PCGC_CSR_PLLPD_BIT];
            pll_mode_ff <= io_wdata_i[PCGC_CSR_MODE_BIT];
        end
    end

    assign pll_reset_o = pll_rst_ff;
    assign pll_powerdown_o = pll_pd_ff;
    assign group_src_pll_o = pll_mode_ff;

    // ****************************************************************
    // Multiplier and prescaler registers
    // ****************************************************************
    logic [4:0] mult_ff;
    logic [4:0] pre_ff;
    logic pre_en_ff;

    // Field writes; reserved bits are not stored
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            mult_ff <= PCGC_MULT_RST;
            pre_ff <= PCGC_PRESCALE_RST;
            pre_en_ff <= PCGC_PRESCALE_EN_RST;
        end
        else
        begin
            if (wr_mult)
                mult_ff <= io_wdata_i[PCGC_FIELD_W-1:0];
            if (wr_pre)
            begin
                pre_ff <= io_wdata_i[PCGC_FIELD_W-1:0];
                pre_en_ff <= io_wdata_i[PCGC_PRESCALE_EN_BIT];
            end
        end
    end

    // Decoded ratios for the analog PLL
    assign multiplier_field_o = mult_ff;
    assign multiplier_valid_o = (mult_ff >= PCGC_MULT_MIN) &&
                                (mult_ff <= PCGC_MULT_MAX);
    assign multiplier_factor_o = multiplier_valid_o ? mult_ff[3:0]
                                                    : 4'h0;
    assign prescaler_field_o = pre_ff;
    assign prescaler_divisor_o = {1'b0, pre_ff} + 6'h01;
    assign prescaler_enable_o = pre_en_ff;

    // ****************************************************************
    // Plain stored words: source select, group dividers, others
    // ****************************************************************
    logic [15:0] plain_ff [PCGC_PLAIN_NUM];
    logic [PCGC_PLAIN_NUM-1:0] plain_hit;

    // One stored word per address in the table
    generate
        for (genvar g = 0; g < PCGC_PLAIN_NUM; g++)
        begin : gen_plain
            assign plain_hit[g] = (io_addr_i == PCGC_PLAIN_ADDR[g]);
            always_ff @(posedge clk_sys_i)
            begin
                if (reset_i)
                    plain_ff[g] <= PCGC_PLAIN_RST[g];
                else if (io_wr_i && plain_hit[g])
                    plain_ff[g] <= io_wdata_i;
            end
        end
    endgenerate

    // Group dividers act on whatever core clock is selected
    assign fast_divider_field_o = plain_ff[PCGC_IDX_FASTDIV];
    assign slow_divider_field_o = plain_ff[PCGC_IDX_SLOWDIV];
    assign memif_divider_field_o = plain_ff[PCGC_IDX_MEMDIV];
    assign core_clock_source_select_o = plain_ff[PCGC_IDX_CORESEL];

    // ****************************************************************
    // Oscillator power-down
    // ****************************************************************
    wire ext_clk_source = plain_ff[PCGC_IDX_CLKMODE][PCGC_CLKMODE_SRC_BIT];
    // Crystal source waits for clock generator idle
    assign osc_powerdown_o = osc_pd_ff &
                             (ext_clk_source | clockgen_idle_i);

    // ****************************************************************
    // Oscillator stabilisation counter
    // ****************************************************************
    localparam logic [PCGC_OSC_CNT_W-1:0] OSC_DONE =
        PCGC_OSC_CNT_W'(OSC_STABLE_CYCLES);
    logic [PCGC_OSC_CNT_W-1:0] osc_cnt_ff;
    wire osc_done = (osc_cnt_ff == OSC_DONE);
    wire [PCGC_OSC_CNT_W-1:0] nxt_osc_cnt =
        osc_done ? osc_cnt_ff : osc_cnt_ff + 1'b1;

    // Restarts at reset and while the oscillator is powered down
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i || osc_powerdown_o)
            osc_cnt_ff <= '0;
        else
            osc_cnt_ff <= nxt_osc_cnt;
    end

    assign osc_stable_o = osc_done | cnt_disable_sync | test_sync;

    // ****************************************************************
    // Lock status and lock event
    // ****************************************************************
    logic lock_d_ff;
    // PLL cannot be locked while held in reset or powered down
    assign lock_status_o = lock_sync & ~pll_rst_ff & ~pll_pd_ff;

    // Previous lock status for edge detection
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            lock_d_ff <= 1'b0;
        else
            lock_d_ff <= lock_status_o;
    end

    assign lock_event_o = lock_status_o & ~lock_d_ff;

    // ****************************************************************
    // Read data
    // ****************************************************************
    wire [15:0] csr_rd = {9'h000, osc_stable_o, lock_status_o, 1'b0,
        pll_rst_ff, osc_pd_ff, pll_pd_ff, pll_mode_ff};
    logic [15:0] plain_rd;
    logic [15:0] rdata_ff;

    // OR of the selected plain words; unmapped reads return zero
    always_comb
    begin
        plain_rd = 16'h0000;
        for (int i = 0; i < PCGC_PLAIN_NUM; i++)
            plain_rd = plain_rd | (plain_hit[i] ? plain_ff[i] : 16'h0000);
    end

    wire [15:0] nxt_rdata = (hit_csr ? csr_rd : 16'h0000) |
        (hit_mult ? {11'h000, mult_ff} : 16'h0000) |
        (hit_pre ? {pre_en_ff, 10'h000, pre_ff} : 16'h0000) |
        plain_rd;

    // Read data registered one cycle after the strobe
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            rdata_ff <= 16'h0000;
        else if (io_rd_i)
            rdata_ff <= nxt_rdata;
    end

    assign io_rdata_o = rdata_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    chk_memif_source: assert property (
        !$past(reset_i, 2) |->
        memif_ext_src_o == $past(memif_clock_source_pin_i, 2))
        else $error("memory clock select does not follow pin");

    chk_stable_count: assert property (
        osc_powerdown_o |=> !osc_stable_o || cnt_disable_sync || test_sync)
        else $error("stable bit set before count done");

    chk_stable_done: assert property (
        (osc_cnt_ff == OSC_DONE - 1'b1) && !osc_powerdown_o
        |=> osc_stable_o)
        else $error("stable bit missing after count");

    chk_lock_reset: assert property (
        pll_rst_ff |-> !lock_status_o)
        else $error("lock shown while PLL in reset");

    chk_pll_release: assert property (
        wr_csr && !io_wdata_i[PCGC_CSR_PLLRESET_BIT] |=> !pll_reset_o)
        else $error("PLL reset not released by write");

    chk_osc_pwrdn: assert property (
        osc_powerdown_o |-> osc_pd_ff && (ext_clk_source || clockgen_idle_i))
        else $error("oscillator powered down too early");

    chk_pll_pwrdn: assert property (
        wr_csr && io_wdata_i[PCGC_CSR_PLLPD_BIT] |=> pll_powerdown_o)
        else $error("PLL power-down write ignored");

    chk_reserved_zero: assert property (
        io_rd_i && hit_csr |=> io_rdata_o[15:7] == 9'h000 && !io_rdata_o[4])
        else $error("reserved status bits not zero");

    chk_mode_write: assert property (
        wr_csr |=> group_src_pll_o == $past(io_wdata_i[PCGC_CSR_MODE_BIT]))
        else $error("mode bit not taken");

    chk_mult_code: assert property (
        multiplier_valid_o == (mult_ff inside {[5'h02:5'h0f]}))
        else $error("multiplier code validity wrong");

    chk_div_code: assert property (
        prescaler_divisor_o == 6'(pre_ff) + 6'd1)
        else $error("prescaler divisor wrong");

    chk_lock_event: assert property (
        lock_event_o |-> lock_status_o ##1 !lock_event_o)
        else $error("lock event not a single pulse on rise");

    chk_mult_map: assert property (
        wr_mult ##1 !wr_mult ##1 (io_rd_i && hit_mult && !wr_mult)
        |=> io_rdata_o[4:0] == $past(io_wdata_i[4:0], 3))
        else $error("multiplier read back wrong");

endmodule

// file: sim/tb_pcgc_clock_control.sv
// Testbench for the clock group control block: registers and clock outputs
`timescale 1ns/1ps
module tb_pcgc_clock_control
    import pcgc_pkg::*;
();
    // ****************************************************************
    // Signals and design instance
    // ****************************************************************
    localparam int STABLE_N = 20;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [15:0] io_addr_i = 16'h0000;
    logic io_wr_i = 1'b0;
    logic io_rd_i = 1'b0;
    logic [15:0] io_wdata_i = 16'h0000;
    logic [15:0] io_rdata_o;
    logic memif_clock_source_pin_i = 1'b0;
    logic memif_external_clock_pin_i = 1'b0;
    logic bridge_clk_i = 1'b0;
    logic memif_clk_o, memif_ext_src_o;
    logic pll_lock_raw_i = 1'b0;
    logic osc_count_disable_i = 1'b0;
    logic test_mode_i = 1'b0;
    logic clockgen_idle_i = 1'b0;
    logic pll_reset_o, pll_powerdown_o, osc_powerdown_o, group_src_pll_o;
    logic [4:0] multiplier_field_o, prescaler_field_o;
    logic multiplier_valid_o, prescaler_enable_o;
    logic [3:0] multiplier_factor_o;
    logic [5:0] prescaler_divisor_o;
    logic [15:0] fast_divider_field_o, slow_divider_field_o;
    logic [15:0] memif_divider_field_o, core_clock_source_select_o;
    logic lock_status_o, osc_stable_o, lock_event_o;
    int err_count = 0;
    int num_checks = 0;
    int i, n;
    logic [4:0] c;
    logic [15:0] e;

    pcgc_clock_control #(.OSC_STABLE_CYCLES(STABLE_N)) pcgc_clock_control_i (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
        .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
        .memif_clock_source_pin_i(memif_clock_source_pin_i),
        .memif_external_clock_pin_i(memif_external_clock_pin_i),
        .bridge_clk_i(bridge_clk_i), .memif_clk_o(memif_clk_o),
        .memif_ext_src_o(memif_ext_src_o), .pll_lock_raw_i(pll_lock_raw_i),
        .osc_count_disable_i(osc_count_disable_i),
        .test_mode_i(test_mode_i), .clockgen_idle_i(clockgen_idle_i),
        .pll_reset_o(pll_reset_o), .pll_powerdown_o(pll_powerdown_o),
        .osc_powerdown_o(osc_powerdown_o),
        .group_src_pll_o(group_src_pll_o),
        .multiplier_field_o(multiplier_field_o),
        .multiplier_valid_o(multiplier_valid_o),
        .multiplier_factor_o(multiplier_factor_o),
        .prescaler_field_o(prescaler_field_o),
        .prescaler_divisor_o(prescaler_divisor_o),
        .prescaler_enable_o(prescaler_enable_o),
        .fast_divider_field_o(fast_divider_field_o),
        .slow_divider_field_o(slow_divider_field_o),
        .memif_divider_field_o(memif_divider_field_o),
        .core_clock_source_select_o(core_clock_source_select_o),
        .lock_status_o(lock_status_o), .osc_stable_o(osc_stable_o),
        .lock_event_o(lock_event_o));

    // ****************************************************************
    // Clock, bus tasks and report
    // ****************************************************************
    // 40 MHz system clock
    initial
    begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        io_wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        io_addr_i <= a;
        io_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        io_rd_i <= 1'b0;
        #1;
        d = io_rdata_o;
    endtask

    task automatic rchk(input string what, input logic [15:0] a,
        input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        check(what, exp, d);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Watchdog against a hung sequence
    initial
    begin
        #200000;
        err_count++;
        stop_test();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        // Reset values while the oscillator count runs
        rchk("csr reset", PCGC_CSR_ADDR, 16'h0008);
        check("pll reset out", 16'h1, 16'(pll_reset_o));
        rchk("mult reset", PCGC_MULT_ADDR, 16'h0000);
        rchk("prescale reset", PCGC_PRESCALE_ADDR, 16'h8000);
        // Plain words: reset value, write, read back
        for (i = 0; i < PCGC_PLAIN_NUM; i++)
        begin
            rchk("plain reset", PCGC_PLAIN_ADDR[i], PCGC_PLAIN_RST[i]);
            wr(PCGC_PLAIN_ADDR[i], 16'h5a30 ^ 16'(i));
            rchk("plain rw", PCGC_PLAIN_ADDR[i], 16'h5a30 ^ 16'(i));
        end
        check("core sel", 16'h5a30, core_clock_source_select_o);
        check("fast div", 16'h5a31, fast_divider_field_o);
        check("slow div", 16'h5a32, slow_divider_field_o);
        check("memif div", 16'h5a33, memif_divider_field_o);
        wr(16'h1c84, 16'hffff);
        rchk("unmapped", 16'h1c84, 16'h0000);
        rchk("core sel kept", PCGC_CORESEL_ADDR, 16'h5a30);
        check("stable done", 16'h1, 16'(osc_stable_o));
        rchk("csr stable", PCGC_CSR_ADDR, 16'h0048);
        // Every multiplier and prescaler code
        for (i = 0; i < 32; i++)
        begin
            c = 5'(i);
            wr(PCGC_MULT_ADDR, {11'h7ff, c});
            check("mult field", 16'(c), 16'(multiplier_field_o));
            e = (c >= 5'h02 && c <= 5'h0f) ? {12'h000, c[3:0]} : 16'h0000;
            check("mult factor", e, 16'(multiplier_factor_o));
            check("mult valid", 16'(e != 0), 16'(multiplier_valid_o));
            rchk("mult word", PCGC_MULT_ADDR, {11'h000, c});
            wr(PCGC_PRESCALE_ADDR, {i[0], 10'h3ff, c});
            check("pre field", 16'(c), 16'(prescaler_field_o));
            check("pre div", 16'(i + 1), 16'(prescaler_divisor_o));
            check("pre en", 16'(i[0]), 16'(prescaler_enable_o));
            rchk("pre word", PCGC_PRESCALE_ADDR, {i[0], 10'h000, c});
        end
        // Control bits 3 to 1 set, mode bit clear, reserved bits stay zero, lock held off
        @(posedge clk_sys_i);
        pll_lock_raw_i <= 1'b1;
        wr(PCGC_CSR_ADDR, 16'hfffe);
        rd(PCGC_CSR_ADDR, e);
        check("csr fields", 16'h000e, e & 16'hffbf);
        check("pll pd out", 16'h1, 16'(pll_powerdown_o));
        check("group src", 16'h0, 16'(group_src_pll_o));
        check("lock in pd", 16'h0, 16'(lock_status_o));
        wr(PCGC_CSR_ADDR, 16'h0008);
        cyc(40);
        check("lock in reset", 16'h0, 16'(lock_status_o));
        // Release the PLL and count lock event pulses
        wr(PCGC_CSR_ADDR, 16'h0000);
        n = 0;
        repeat (6)
        begin
            n += int'(lock_event_o === 1'b1);
            @(posedge clk_sys_i);
            #1;
        end
        check("lock pulses", 16'h1, 16'(n));
        rd(PCGC_CSR_ADDR, e);
        check("csr lock", 16'h0020, e & 16'hffbf);
        wr(PCGC_CSR_ADDR, 16'h0001);
        check("group src pll", 16'h1, 16'(group_src_pll_o));
        @(posedge clk_sys_i);
        pll_lock_raw_i <= 1'b0;
        cyc(4);
        check("lock lost", 16'h0, 16'(lock_status_o));
        // Oscillator power-down with crystal and external source
        wr(PCGC_CLKMODE_ADDR, 16'h0000);
        wr(PCGC_CSR_ADDR, 16'h0004);
        check("osc pd wait", 16'h0, 16'(osc_powerdown_o));
        @(posedge clk_sys_i);
        clockgen_idle_i <= 1'b1;
        #1;
        check("osc pd idle", 16'h1, 16'(osc_powerdown_o));
        @(posedge clk_sys_i);
        clockgen_idle_i <= 1'b0;
        wr(PCGC_CLKMODE_ADDR, 16'h0001);
        check("osc pd ext", 16'h1, 16'(osc_powerdown_o));
        wr(PCGC_CSR_ADDR, 16'h0000);
        check("osc pd off", 16'h0, 16'(osc_powerdown_o));
        check("stable restart", 16'h0, 16'(osc_stable_o));
        cyc(STABLE_N + 5);
        check("stable again", 16'h1, 16'(osc_stable_o));
        // Memory clock source selection
        @(posedge clk_sys_i);
        bridge_clk_i <= 1'b1;
        cyc(3);
        check("memif bridge", 16'h1, 16'(memif_clk_o));
        check("memif src 0", 16'h0, 16'(memif_ext_src_o));
        @(posedge clk_sys_i);
        bridge_clk_i <= 1'b0;
        memif_external_clock_pin_i <= 1'b1;
        memif_clock_source_pin_i <= 1'b1;
        #1;
        check("memif bridge 0", 16'h0, 16'(memif_clk_o));
        cyc(3);
        check("memif src 1", 16'h1, 16'(memif_ext_src_o));
        check("memif ext", 16'h1, 16'(memif_clk_o));
        // Stable forced by test mode, then by counter disable
        for (i = 0; i < 2; i++)
        begin
            @(posedge clk_sys_i);
            reset_i <= 1'b1;
            test_mode_i <= ~i[0];
            osc_count_disable_i <= i[0];
            repeat (5) @(posedge clk_sys_i);
            reset_i <= 1'b0;
            cyc(4);
            check("stable forced", 16'h1, 16'(osc_stable_o));
            check("pll reset again", 16'h1, 16'(pll_reset_o));
        end
        stop_test();
    end
endmodule
